// *** design/sbst_buf.sv ***
`timescale 1ns/100ps
// two-entry skid buffer; every output comes from a flip-flop
module sbst_buf
  import sbst_pkg::*;
#(
  parameter int WIDTH = `SBST_BSR_LEN
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  typedef struct packed {
    logic [WIDTH-1:0] head;
    logic head_v;
    logic [WIDTH-1:0] skid;
    logic skid_v;
  } sbst_buf_st_t;

  sbst_buf_st_t st_q;
  sbst_buf_st_t st_d;

  // head feeds the reader, skid catches a word while the head is stalled
  always_comb
  begin
    logic pop;
    logic push;
    pop = 1'b0;
    push = 1'b0;
    st_d = st_q;
    pop = st_q.head_v & out_ready;
    push = in_valid & ~st_q.skid_v;
    if (!st_q.head_v || pop)
    begin
      if (st_q.skid_v)
      begin
        st_d.head = st_q.skid;
        st_d.head_v = 1'b1;
        st_d.skid_v = 1'b0;
      end
      else
      begin
        st_d.head = in_data;
        st_d.head_v = push;
      end
    end
    else if (push)
    begin
      st_d.skid = in_data;
      st_d.skid_v = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      st_q <= '0;
    else if (ce)
      st_q <= st_d;
  end

  assign in_ready = ~st_q.skid_v;
  assign out_valid = st_q.head_v;
  assign out_data = st_q.head;
endmodule : sbst_buf

// *** design/sbst_map.svh ***
// Functional notes
// R1 - test inputs sampled on test clock rise
// R2 - serial out changes on test clock fall
// R3 - undriven mode select and data read high
// R4 - serial in enters selected register top bit
// R5 - serial out taken from selected register bottom
// R6 - output driver enable follows TAP state
// R7 - five high mode select rises reach reset
// R8 - TAP reset leaves memory operation untouched
// R9 - power-up reset leaves serial out undriven
// R10 - loaded instruction picks one scan register
// R11 - three-bit instruction register, serially loaded
// R12 - reset state loads identification instruction
// R13 - Capture-IR loads binary 01 into bottom bits
// R14 - one-bit bypass register in scan path
// R15 - bypass cleared low under BYPASS instruction
// R16 - state moves decided by sampled mode select
// R17 - unused port has test clock held low
// R18 - stays compatible with compliant chain neighbours
// R19 - eight codes, five used, three reserved
// R20 - identification capture loads fixed 32-bit code
// R21 - boundary register holds 71 bits
// R22 - new instruction acts only at Update-IR
// R23 - full sixteen-state TAP state machine
// R24 - serial out driven only in shift states
`ifndef SBST_MAP_SVH
`define SBST_MAP_SVH
`define SBST_IR_LEN 3
`define SBST_ID_LEN 32
`define SBST_BSR_LEN 71
`define SBST_IR_CAPT 3'h1
`define SBST_IR_EXTEST 3'h0
`define SBST_IR_IDCODE 3'h1
`define SBST_IR_SAMPLEZ 3'h2
`define SBST_IR_RSVD0 3'h3
`define SBST_IR_SAMPLE 3'h4
`define SBST_IR_RSVD1 3'h5
`define SBST_IR_RSVD2 3'h6
`define SBST_IR_BYPASS 3'h7
`define SBST_ID_DEFAULT 32'h5a5a_a001
`endif

// *** design/sbst_pkg.sv ***
`include "sbst_map.svh"
package sbst_pkg;
  typedef enum logic [15:0] {
    SBST_TLR = 16'h0001,
    SBST_RTI = 16'h0002,
    SBST_SEL_DR = 16'h0004,
    SBST_CAP_DR = 16'h0008,
    SBST_SH_DR = 16'h0010,
    SBST_EX1_DR = 16'h0020,
    SBST_PA_DR = 16'h0040,
    SBST_EX2_DR = 16'h0080,
    SBST_UPD_DR = 16'h0100,
    SBST_SEL_IR = 16'h0200,
    SBST_CAP_IR = 16'h0400,
    SBST_SH_IR = 16'h0800,
    SBST_EX1_IR = 16'h1000,
    SBST_PA_IR = 16'h2000,
    SBST_EX2_IR = 16'h4000,
    SBST_UPD_IR = 16'h8000
  } sbst_state_t;

  // which data register sits in the scan path
  typedef enum logic [2:0] {
    SBST_DR_BYP = 3'h1,
    SBST_DR_ID = 3'h2,
    SBST_DR_BSR = 3'h4
  } sbst_dr_t;

  typedef struct packed {
    logic [1:0] tck_sy;
    logic tck_prev;
    logic [1:0] tms_sy;
    logic [1:0] tmsd_sy;
    logic [1:0] tdi_sy;
    logic [1:0] tdid_sy;
    logic [`SBST_BSR_LEN-1:0] ring_s1;
    logic [`SBST_BSR_LEN-1:0] ring_s2;
    sbst_state_t state;
    logic [`SBST_IR_LEN-1:0] ir_sh;
    logic [`SBST_IR_LEN-1:0] ir;
    logic byp;
    logic [`SBST_ID_LEN-1:0] id_sh;
    logic [`SBST_BSR_LEN-1:0] bsr;
    logic tdo;
    logic tdo_oe;
    logic out_hiz;
    logic in_reset;
    logic push;
    logic [`SBST_BSR_LEN-1:0] push_data;
    logic overrun;
  } sbst_tap_st_t;
endpackage : sbst_pkg

// *** design/sbst_tap.sv ***
`timescale 1ns/100ps
// boundary-scan test access port, oversampling the test clock on clk
module sbst_tap
  import sbst_pkg::*;
#(
  // identification value is arbitrary
  parameter logic [`SBST_ID_LEN-1:0] ID_CODE = `SBST_ID_DEFAULT
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic tck,
  input wire logic tms,
  input wire logic tms_drv,
  input wire logic tdi,
  input wire logic tdi_drv,
  input wire logic [`SBST_BSR_LEN-1:0] io_ring,
  output logic tdo,
  output logic tdo_oe,
  output logic sram_out_hiz,
  output logic tap_in_reset,
  output logic dr_valid,
  input wire logic dr_ready,
  output logic [`SBST_BSR_LEN-1:0] dr_data,
  output logic dr_overrun
);
  sbst_tap_st_t st_q;
  sbst_tap_st_t st_d;
  logic buf_ready;

  // instruction decode, shared by capture, shift, update and output
  function automatic sbst_dr_t dr_sel(input logic [`SBST_IR_LEN-1:0] ir);
    sbst_dr_t k;
    k = SBST_DR_BYP;
    case (ir)
      `SBST_IR_EXTEST: k = SBST_DR_BSR;
      `SBST_IR_IDCODE: k = SBST_DR_ID;
      `SBST_IR_SAMPLEZ: k = SBST_DR_BSR;
      `SBST_IR_SAMPLE: k = SBST_DR_BSR;
      `SBST_IR_BYPASS: k = SBST_DR_BYP;
      // reserved codes fall back to the bypass path, keeping the chain short
      `SBST_IR_RSVD0: k = SBST_DR_BYP;
      `SBST_IR_RSVD1: k = SBST_DR_BYP;
      `SBST_IR_RSVD2: k = SBST_DR_BYP;
      default: k = SBST_DR_BYP;
    endcase
    return k;
  endfunction : dr_sel

  // memory outputs float only under the two capture-with-float codes
  function automatic logic hiz_sel(input logic [`SBST_IR_LEN-1:0] ir);
    return (ir == `SBST_IR_EXTEST) || (ir == `SBST_IR_SAMPLEZ);
  endfunction : hiz_sel

  // standard sixteen-state walk, one step per test clock rise
  function automatic sbst_state_t tap_next(input sbst_state_t s,
                                           input logic m);
    sbst_state_t n;
    n = SBST_TLR;
    case (s)
      SBST_TLR: n = m ? SBST_TLR : SBST_RTI;
      SBST_RTI: n = m ? SBST_SEL_DR : SBST_RTI;
      SBST_SEL_DR: n = m ? SBST_SEL_IR : SBST_CAP_DR;
      SBST_CAP_DR: n = m ? SBST_EX1_DR : SBST_SH_DR;
      SBST_SH_DR: n = m ? SBST_EX1_DR : SBST_SH_DR;
      SBST_EX1_DR: n = m ? SBST_UPD_DR : SBST_PA_DR;
      SBST_PA_DR: n = m ? SBST_EX2_DR : SBST_PA_DR;
      SBST_EX2_DR: n = m ? SBST_UPD_DR : SBST_SH_DR;
      SBST_UPD_DR: n = m ? SBST_SEL_DR : SBST_RTI;
      SBST_SEL_IR: n = m ? SBST_TLR : SBST_CAP_IR;
      SBST_CAP_IR: n = m ? SBST_EX1_IR : SBST_SH_IR;
      SBST_SH_IR: n = m ? SBST_EX1_IR : SBST_SH_IR;
      SBST_EX1_IR: n = m ? SBST_UPD_IR : SBST_PA_IR;
      SBST_PA_IR: n = m ? SBST_EX2_IR : SBST_PA_IR;
      SBST_EX2_IR: n = m ? SBST_UPD_IR : SBST_SH_IR;
      SBST_UPD_IR: n = m ? SBST_SEL_DR : SBST_RTI;
      default: n = SBST_TLR;
    endcase
    return n;
  endfunction : tap_next

  // next-state logic for the whole port
  always_comb
  begin
    logic rise;
    logic fall;
    logic ms;
    logic di;
    sbst_dr_t kind;
    rise = 1'b0;
    fall = 1'b0;
    ms = 1'b0;
    di = 1'b0;
    kind = SBST_DR_BYP;
    st_d = st_q;

    // two-stage synchronisers; stage 0 feeds only stage 1
    st_d.tck_sy = {st_q.tck_sy[0], tck};
    st_d.tms_sy = {st_q.tms_sy[0], tms};
    st_d.tmsd_sy = {st_q.tmsd_sy[0], tms_drv};
    st_d.tdi_sy = {st_q.tdi_sy[0], tdi};
    st_d.tdid_sy = {st_q.tdid_sy[0], tdi_drv};
    st_d.ring_s1 = io_ring;
    st_d.ring_s2 = st_q.ring_s1;
    st_d.tck_prev = st_q.tck_sy[1];

    // edges of the oversampled test clock; a clock held low gives none
    rise = st_q.tck_sy[1] & ~st_q.tck_prev; // R1 R17
    fall = ~st_q.tck_sy[1] & st_q.tck_prev; // R2

    // an undriven pin reads as the pull-up level
    ms = st_q.tmsd_sy[1] ? st_q.tms_sy[1] : 1'b1; // R3
    di = st_q.tdid_sy[1] ? st_q.tdi_sy[1] : 1'b1; // R3
    kind = dr_sel(st_q.ir); // R10

    st_d.push = 1'b0;

    // register actions happen at the rise, in the state being left, besides the ir reload on entering reset
    if (rise)
    begin
      st_d.state = tap_next(st_q.state, ms); // R16 R23 R7
      // entering reset must drop a float code at once, not on leaving
      if (st_d.state == SBST_TLR)
        st_d.ir = `SBST_IR_IDCODE; // R12
      case (st_q.state)
        SBST_TLR:
        begin
          st_d.ir = `SBST_IR_IDCODE; // R12
        end
        SBST_CAP_IR:
        begin
          st_d.ir_sh = `SBST_IR_CAPT; // R13
        end
        SBST_SH_IR:
        begin
          // msb takes serial in, lsb falls out toward serial out
          st_d.ir_sh = {di, st_q.ir_sh[`SBST_IR_LEN-1:1]}; // R11 R4
        end
        SBST_UPD_IR:
        begin
          st_d.ir = st_q.ir_sh; // R22
        end
        SBST_CAP_DR:
        begin
          case (kind)
            SBST_DR_BYP: st_d.byp = 1'b0; // R15 R14
            SBST_DR_ID: st_d.id_sh = ID_CODE; // R20
            SBST_DR_BSR: st_d.bsr = st_q.ring_s2; // R21
            default: st_d.byp = 1'b0;
          endcase
        end
        SBST_SH_DR:
        begin
          // only the selected register moves; the others hold
          case (kind)
            SBST_DR_BYP: st_d.byp = di; // R14 R4
            SBST_DR_ID:
              st_d.id_sh = {di, st_q.id_sh[`SBST_ID_LEN-1:1]}; // R4
            SBST_DR_BSR:
              st_d.bsr = {di, st_q.bsr[`SBST_BSR_LEN-1:1]}; // R4 R21
            default: st_d.byp = di;
          endcase
        end
        SBST_UPD_DR:
        begin
          // no preload: the shifted word is handed to the user side only
          if (kind == SBST_DR_BSR)
          begin
            st_d.push = 1'b1;
            st_d.push_data = st_q.bsr;
          end
        end
        default:
        begin
          st_d.byp = st_q.byp;
        end
      endcase
    end

    // a word that meets a full buffer is flagged rather than silently lost
    if (st_q.push && !buf_ready)
      st_d.overrun = 1'b1;

    // serial out and its enable change only at the fall
    if (fall)
    begin
      st_d.tdo_oe = (st_q.state == SBST_SH_IR) ||
                    (st_q.state == SBST_SH_DR); // R6 R24
      st_d.tdo = 1'b0;
      if (st_q.state == SBST_SH_IR)
        st_d.tdo = st_q.ir_sh[0]; // R5
      else if (st_q.state == SBST_SH_DR)
      begin
        case (kind)
          SBST_DR_BYP: st_d.tdo = st_q.byp; // R5 R14
          SBST_DR_ID: st_d.tdo = st_q.id_sh[0]; // R5
          SBST_DR_BSR: st_d.tdo = st_q.bsr[0]; // R5
          default: st_d.tdo = st_q.byp;
        endcase
      end
    end

    // the memory path sees only the float request, never the TAP reset
    st_d.out_hiz = hiz_sel(st_q.ir); // R8 R18
    st_d.in_reset = (st_q.state == SBST_TLR);
  end

  // power-up reset: reset state, identification code, serial out undriven
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      st_q <= '0;
      st_q.state <= SBST_TLR; // R9
      st_q.ir <= `SBST_IR_IDCODE; // R12
      st_q.in_reset <= 1'b1;
      st_q.tck_prev <= 1'b0;
    end
    else if (ce)
      st_q <= st_d;
  end

  // boundary words shifted in, held for a reader that may stall
  sbst_buf #(
    .WIDTH(`SBST_BSR_LEN)
  ) u_buf (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .in_valid(st_q.push),
    .in_ready(buf_ready),
    .in_data(st_q.push_data),
    .out_valid(dr_valid),
    .out_ready(dr_ready),
    .out_data(dr_data)
  );

  // top-level outputs straight from the state flops
  assign tdo = st_q.tdo;
  assign tdo_oe = st_q.tdo_oe; // R9
  assign sram_out_hiz = st_q.out_hiz;
  assign tap_in_reset = st_q.in_reset;
  assign dr_overrun = st_q.overrun;
endmodule : sbst_tap

// *** sim/sbst_ctl_model.sv ***
`timescale 1ns/100ps
// scan controller; tck stands low between steps
module sbst_ctl_model (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // one 48 ns test clock; tdo is taken at the rise
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #24 tck = 1'b1;
    o = tdo;
    #12 tdi = ~d; // hold has run out, so the line stops showing d
    #12 tck = 1'b0;
  endtask : step
endmodule : sbst_ctl_model

// *** sim/sbst_tap_assertions.sv ***
`timescale 1ns/100ps
`include "sbst_map.svh"
// pin-level checks of the scan port, all on clk
module sbst_tap_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tck,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic sram_out_hiz,
  input wire logic tap_in_reset,
  input wire logic dr_valid,
  input wire logic dr_ready,
  input wire logic [`SBST_BSR_LEN-1:0] dr_data,
  input wire logic dr_overrun
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // ir reload happens at the rise entering reset, so no float is left once reset ends
  sequence s_no_float;
    !sram_out_hiz [*2];
  endsequence
  a_idle_oe_low: assert property (tap_in_reset |-> !tdo_oe)
    else $error("tdo enabled in reset state");
  a_tdo_idle_zero: assert property (!tdo_oe |-> !tdo)
    else $error("tdo high while undriven");
  a_tdo_fall_only: assert property
    ($changed(tdo) |-> !$past(tck) && !$past(tck, 2))
    else $error("tdo moved in a tck high phase");
  a_oe_fall_only: assert property ($changed(tdo_oe) |-> !$past(tck))
    else $error("tdo enable moved in a tck high phase");
  a_reset_id_instr: assert property
    ($fell(tap_in_reset) |-> s_no_float)
    else $error("memory outputs float after reset state");
  a_hiz_on_rise: assert property ($changed(sram_out_hiz) |-> $past(tck))
    else $error("instruction changed away from a tck rise");
  a_head_holds: assert property
    (dr_valid && !dr_ready |=> dr_valid && $stable(dr_data))
    else $error("buffer head lost before taken");
  a_overrun_sticky: assert property (dr_overrun |=> dr_overrun)
    else $error("overrun flag cleared");
endmodule : sbst_tap_chk

bind sbst_tap sbst_tap_chk u_chk (.clk(clk), .reset_n(reset_n), .tck(tck),
  .tdo(tdo), .tdo_oe(tdo_oe), .sram_out_hiz(sram_out_hiz),
  .tap_in_reset(tap_in_reset), .dr_valid(dr_valid), .dr_ready(dr_ready),
  .dr_data(dr_data), .dr_overrun(dr_overrun));

// *** sim/sbst_tap_tb.sv ***
`timescale 1ns/100ps
`include "sbst_map.svh"
// scan port bench; the model plays the far-side controller
module sbst_tap_tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic tms_drv = 1'b1;
  logic tdi_drv = 1'b1;
  logic dr_ready = 1'b0;
  logic [70:0] io_ring = '0;
  logic [70:0] dr_data;
  logic tck, tms, tdi, tdo, tdo_oe, hiz, in_rst, dr_valid, dr_overrun;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;

  always #2.5 clk = ~clk;

  sbst_ctl_model u_ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  sbst_tap u_dut (.clk(clk), .reset_n(reset_n), .ce(1'b1), .tck(tck),
    .tms(tms), .tms_drv(tms_drv), .tdi(tdi), .tdi_drv(tdi_drv),
    .io_ring(io_ring), .tdo(tdo), .tdo_oe(tdo_oe), .sram_out_hiz(hiz),
    .tap_in_reset(in_rst), .dr_valid(dr_valid), .dr_ready(dr_ready),
    .dr_data(dr_data), .dr_overrun(dr_overrun));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [70:0] seen, input logic [70:0] exp,
    input string what);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // full IR or DR scan from idle back to idle
  task automatic scan(input logic ir, input int n, input logic [70:0] d,
    output logic [70:0] q);
    logic o;
    q = '0;
    u_ctl.step(1'b1, 1'b0, o);
    if (ir)
      u_ctl.step(1'b1, 1'b0, o);
    u_ctl.step(1'b0, 1'b0, o);
    u_ctl.step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++)
    begin
      u_ctl.step(i == n - 1, d[i], o);
      q[i] = o;
    end
    u_ctl.step(1'b1, 1'b0, o);
    u_ctl.step(1'b0, 1'b0, o);
    repeat (6) @(negedge clk);
  endtask : scan

  task automatic t_reset();
    logic o;
    chk(in_rst, 1'b1, "reset state");
    chk(tdo_oe, 1'b0, "tdo enable");
    u_ctl.step(1'b0, 1'b0, o);
    $display("reset test done");
  endtask : t_reset

  task automatic t_id();
    logic [70:0] q;
    scan(1'b0, 32, '0, q);
    chk(q[31:0], `SBST_ID_DEFAULT, "id code");
    chk(dr_valid, 1'b0, "no word");
    $display("id test done");
  endtask : t_id

  task automatic t_byp();
    logic [70:0] q;
    logic [2:0] c [4] = '{`SBST_IR_BYPASS, 3'h3, 3'h5, 3'h6};
    foreach (c[k])
    begin
      scan(1'b1, 3, 71'(c[k]), q);
      chk(q[2:0], 3'h1, "ir capture");
      scan(1'b0, 8, 71'hb5, q);
      chk(q[7:0], 8'h6a, "bypass");
    end
    $display("bypass test done");
  endtask : t_byp

  // three words against a stalled reader, then drain
  task automatic t_bsr();
    logic [70:0] q;
    logic [70:0] w [3];
    logic [2:0] c [3] = '{3'h0, 3'h2, `SBST_IR_SAMPLE};
    foreach (c[k])
    begin
      w[k] = {32'h1357_9bdf, 39'(c[k])};
      io_ring = ~w[k];
      scan(1'b1, 3, 71'(c[k]), q);
      chk(hiz, c[k] != `SBST_IR_SAMPLE, "outputs float");
      scan(1'b0, 71, w[k], q);
      chk(q, ~w[k], "ring capture");
    end
    chk(dr_overrun, 1'b1, "overrun");
    for (int k = 0; k < 2; k++)
    begin
      chk(dr_valid, 1'b1, "word valid");
      chk(dr_data, w[k], "word");
      dr_ready = 1'b1;
      @(negedge clk);
      dr_ready = 1'b0;
      @(negedge clk);
    end
    chk(dr_valid, 1'b0, "drained");
    $display("boundary test done");
  endtask : t_bsr

  task automatic t_rst5();
    logic [70:0] q;
    logic o;
    scan(1'b1, 3, 71'(`SBST_IR_SAMPLEZ), q);
    u_ctl.step(1'b1, 1'b0, o);
    u_ctl.step(1'b0, 1'b0, o);
    u_ctl.step(1'b0, 1'b0, o);
    repeat (4) u_ctl.step(1'b1, 1'b0, o);
    @(negedge clk);
    tms_drv = 1'b0;
    chk(in_rst, 1'b0, "four rises");
    u_ctl.step(1'b0, 1'b0, o);
    repeat (6) @(negedge clk);
    tms_drv = 1'b1;
    tdi_drv = 1'b0;
    chk(in_rst, 1'b1, "five rises");
    chk(hiz, 1'b0, "id in reset state");
    u_ctl.step(1'b0, 1'b0, o);
    repeat (6) @(negedge clk);
    chk(hiz, 1'b0, "id after reset");
    scan(1'b1, 3, '0, q);
    scan(1'b0, 4, '0, q);
    tdi_drv = 1'b1;
    chk(q[3:0], 4'he, "pulled tdi");
    $display("tap reset test done");
  endtask : t_rst5

  initial
  begin
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_id();
    t_byp();
    t_bsr();
    t_rst5();
    report_and_stop();
  end

  // run needs about 4100 cycles; cut a hang short well past that
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end
endmodule : sbst_tap_tb
